// File: include/oag_defs.svh
/*
  Constants of the operand address generator: prebyte codes, opcode groups and common values.
  Assumes inclusion by bare name from the design file.
*/
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH

// Prebyte codes.
`define OAG_PRE_Y 8'h90
`define OAG_PRE_IYI 8'h91
`define OAG_PRE_IND 8'h92

// Addressing group held in the opcode high nibble.
`define OAG_GRP_BITREL 4'h0
`define OAG_GRP_BIT 4'h1
`define OAG_GRP_REL 4'h2
`define OAG_GRP_RMW_DIR 4'h3
`define OAG_GRP_RMW_IDX 4'h6
`define OAG_GRP_RMW_IDX0 4'h7
`define OAG_GRP_IMM 4'hA
`define OAG_GRP_DIR_S 4'hB
`define OAG_GRP_DIR_L 4'hC
`define OAG_GRP_IDX_L 4'hD
`define OAG_GRP_IDX_S 4'hE
`define OAG_GRP_IDX_0 4'hF

// Common values.
`define OAG_ZERO_BYTE 8'h00
`define OAG_ZERO_WORD 16'h0000
`define OAG_ONE_WORD 16'h0001

`endif

// File: include/oag_pkg.sv
/*
  Types of the operand address generator: modes, sequencer states and the result record.
  Assumes no other package.
*/
package oag_pkg;

  typedef enum logic [4:0] {
    M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX_0, M_IDX_S, M_IDX_L,
    M_IND_S, M_IND_L, M_IIDX_S, M_IIDX_L, M_REL, M_REL_IND,
    M_BIT, M_BIT_IND, M_BITREL, M_BITREL_IND
  } mode_t;

  typedef enum logic [2:0] {
    S_IDLE, S_OPC, S_OPND, S_PTR, S_CALC
  } state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] prebyte;
    mode_t mode;
    logic use_y;
    logic [7:0] operand;
    logic [15:0] ea;
    logic [15:0] target;
    logic [15:0] next_pc;
  } result_t;

endpackage

// File: rtl/operand_address_generator.sv
/*
  Operand address generator: fetches prebyte, opcode, operand bytes and pointers, then forms the
  effective operand address and branch target of one instruction.
  Assumes a byte-wide read port that answers each held request with a one-cycle ack.
*/
// Summary of operation
// RULE1: Inherent opcodes decode from one byte, no operand bytes fetched.
// RULE2: Immediate takes the byte after the opcode as the operand value.
// RULE3: Short direct uses one address byte, page zero only.
// RULE4: Long direct forms a 16-bit address from two following bytes.
// RULE5: Indexed address is unsigned sum of X or Y and the offset.
// RULE6: No-offset indexed uses the index register alone, no operand byte.
// RULE7: Short indexed adds byte offset to index without truncation, up to 1FE.
// RULE8: Long indexed adds a 16-bit offset to the index register.
// RULE9: Indirect fetches a pointer named by the byte after the opcode.
// RULE10: Short indirect reads a one-byte page-zero pointer as address.
// RULE11: Long indirect reads a 16-bit pointer from page zero.
// RULE12: Relative adds a signed byte to the PC of the next instruction.
// RULE13: Read-modify-write opcodes only have short forms: page-zero direct, byte-offset and no-offset indexed.
// RULE14: Indirect indexed adds X or Y to a fetched pointer.
// RULE15: Prebyte 90 turns X forms of the eligible modes into Y forms.
// RULE16: Prebyte 92 turns direct, relative, bit and X offset-indexed forms into indirect forms.
// RULE17: Prebyte 91 turns X indirect indexed into Y indirect indexed.
// RULE18: Words are high byte at lower address, low byte next.
// RULE19: PC advances by the prebyte if any, the opcode, plus exactly the operand bytes of the mode.
`timescale 1ns/10ps
`include "oag_defs.svh"

module operand_address_generator
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Instruction request
  input wire logic start,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] x_idx,
  input wire logic [7:0] y_idx,
  output logic busy_r,
  // Memory read port
  output logic mem_req_r,
  output logic [15:0] mem_addr_r,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  // Result
  output logic done_r,
  output oag_pkg::result_t res_r
);
  import oag_pkg::*;

  function automatic mode_t decode_mode(input logic [7:0] op, input logic [7:0] pre);
    mode_t m;
    logic ind;
    m = M_INH;
    // RULE16 indirect prebyte select
    ind = (pre == `OAG_PRE_IND) || (pre == `OAG_PRE_IYI);
    case (op[7:4])
      `OAG_GRP_BITREL: m = ind ? M_BITREL_IND : M_BITREL;
      `OAG_GRP_BIT: m = ind ? M_BIT_IND : M_BIT;
      `OAG_GRP_REL: m = ind ? M_REL_IND : M_REL;
      `OAG_GRP_RMW_DIR: m = ind ? M_IND_S : M_DIR_S;
      `OAG_GRP_RMW_IDX: m = ind ? M_IIDX_S : M_IDX_S;
      `OAG_GRP_RMW_IDX0: m = M_IDX_0;
      `OAG_GRP_IMM: m = M_IMM;
      `OAG_GRP_DIR_S: m = ind ? M_IND_S : M_DIR_S;
      `OAG_GRP_DIR_L: m = ind ? M_IND_L : M_DIR_L;
      `OAG_GRP_IDX_L: m = ind ? M_IIDX_L : M_IDX_L;
      `OAG_GRP_IDX_S: m = ind ? M_IIDX_S : M_IDX_S;
      `OAG_GRP_IDX_0: m = M_IDX_0;
      default: m = M_INH;
    endcase
    return m;
  endfunction

  function automatic logic pick_y(input mode_t m, input logic [7:0] pre);
    case (m)
      // RULE15 plain Y forms
      M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX_0, M_IDX_S, M_IDX_L: return (pre == `OAG_PRE_Y);
      // RULE17 Y indirect indexed
      M_IIDX_S, M_IIDX_L: return (pre == `OAG_PRE_IYI);
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [1:0] opnd_count(input mode_t m);
    case (m)
      M_INH, M_IDX_0: return 2'h0;
      M_DIR_L, M_IDX_L, M_BITREL, M_BITREL_IND: return 2'h2;
      default: return 2'h1;
    endcase
  endfunction

  function automatic logic [1:0] ptr_count(input mode_t m);
    case (m)
      M_IND_L, M_IIDX_L: return 2'h2;
      M_IND_S, M_IIDX_S, M_REL_IND, M_BIT_IND, M_BITREL_IND: return 2'h1;
      default: return 2'h0;
    endcase
  endfunction

  function automatic logic [15:0] word(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction

  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] d);
    return pc + {{8{d[7]}}, d};
  endfunction

  state_t st_r, st_nxt;
  mode_t mode_r, mode_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0] pre_r, pre_nxt;
  logic [7:0] op_r, op_nxt;
  logic [7:0] b0_r, b0_nxt, b1_r, b1_nxt;
  logic [7:0] p0_r, p0_nxt, p1_r, p1_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic busy_nxt, req_nxt, done_nxt;
  logic [15:0] addr_nxt;
  result_t res_nxt;
  logic [15:0] idx_w;

  always_comb
  begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    pc_nxt = pc_r;
    pre_nxt = pre_r;
    op_nxt = op_r;
    b0_nxt = b0_r;
    b1_nxt = b1_r;
    p0_nxt = p0_r;
    p1_nxt = p1_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    req_nxt = mem_req_r;
    addr_nxt = mem_addr_r;
    done_nxt = 1'b0;
    res_nxt = res_r;
    // RULE5 index select
    idx_w = {`OAG_ZERO_BYTE, (res_r.use_y ? y_idx : x_idx)};
    case (st_r)
      S_IDLE:
      begin
        if (start)
        begin
          pc_nxt = pc_in;
          addr_nxt = pc_in;
          req_nxt = 1'b1;
          busy_nxt = 1'b1;
          pre_nxt = `OAG_ZERO_BYTE;
          st_nxt = S_OPC;
        end
      end
      S_OPC:
      begin
        if (mem_ack)
        begin
          // RULE19 one step per fetched byte
          pc_nxt = pc_r + `OAG_ONE_WORD;
          cnt_nxt = 2'h0;
          // RULE15 prebytes are taken once, then the opcode follows
          if ((pre_r == `OAG_ZERO_BYTE) && ((mem_rdata == `OAG_PRE_Y) || (mem_rdata == `OAG_PRE_IYI) ||
              (mem_rdata == `OAG_PRE_IND)))
          begin
            pre_nxt = mem_rdata;
            addr_nxt = pc_r + `OAG_ONE_WORD;
          end
          else
          begin
            op_nxt = mem_rdata;
            mode_nxt = decode_mode(mem_rdata, pre_r);
            res_nxt.use_y = pick_y(decode_mode(mem_rdata, pre_r), pre_r);
            // RULE1 modes with no operand bytes go straight to the result
            if (opnd_count(decode_mode(mem_rdata, pre_r)) == 2'h0)
            begin
              req_nxt = 1'b0;
              st_nxt = S_CALC;
            end
            else
            begin
              addr_nxt = pc_r + `OAG_ONE_WORD;
              st_nxt = S_OPND;
            end
          end
        end
      end
      S_OPND:
      begin
        if (mem_ack)
        begin
          // RULE19 advance by operand byte
          pc_nxt = pc_r + `OAG_ONE_WORD;
          if (cnt_r == 2'h0)
            b0_nxt = mem_rdata;
          else
            b1_nxt = mem_rdata;
          if ((cnt_r + 2'h1) == opnd_count(mode_r))
          begin
            cnt_nxt = 2'h0;
            // RULE9 pointer location is the first operand byte, in page zero
            if (ptr_count(mode_r) != 2'h0)
            begin
              addr_nxt = word(`OAG_ZERO_BYTE, (cnt_r == 2'h0) ? mem_rdata : b0_r);
              st_nxt = S_PTR;
            end
            else
            begin
              req_nxt = 1'b0;
              st_nxt = S_CALC;
            end
          end
          else
          begin
            addr_nxt = pc_r + `OAG_ONE_WORD;
            cnt_nxt = cnt_r + 2'h1;
          end
        end
      end
      S_PTR:
      begin
        if (mem_ack)
        begin
          if (cnt_r == 2'h0)
            p0_nxt = mem_rdata;
          else
            p1_nxt = mem_rdata;
          if ((cnt_r + 2'h1) == ptr_count(mode_r))
          begin
            req_nxt = 1'b0;
            st_nxt = S_CALC;
          end
          else
          begin
            // RULE18 low byte of a word sits at the next location
            addr_nxt = mem_addr_r + `OAG_ONE_WORD;
            cnt_nxt = cnt_r + 2'h1;
          end
        end
      end
      S_CALC:
      begin
        res_nxt.opcode = op_r;
        res_nxt.prebyte = pre_r;
        res_nxt.mode = mode_r;
        res_nxt.next_pc = pc_r;
        res_nxt.operand = `OAG_ZERO_BYTE;
        res_nxt.ea = `OAG_ZERO_WORD;
        res_nxt.target = pc_r;
        case (mode_r)
          // RULE2 operand value, no address
          M_IMM: res_nxt.operand = b0_r;
          // RULE3 page-zero direct
          M_DIR_S, M_BIT: res_nxt.ea = word(`OAG_ZERO_BYTE, b0_r);
          // RULE4 full-space direct
          M_DIR_L: res_nxt.ea = word(b0_r, b1_r);
          // RULE6 index alone
          M_IDX_0: res_nxt.ea = idx_w;
          // RULE7 nine-bit sum kept whole
          M_IDX_S: res_nxt.ea = idx_w + {`OAG_ZERO_BYTE, b0_r};
          // RULE8 word offset plus index
          M_IDX_L: res_nxt.ea = word(b0_r, b1_r) + idx_w;
          // RULE10 byte pointer
          M_IND_S, M_BIT_IND: res_nxt.ea = word(`OAG_ZERO_BYTE, p0_r);
          // RULE11 word pointer
          M_IND_L: res_nxt.ea = word(p0_r, p1_r);
          // RULE14 pointer plus index
          M_IIDX_S: res_nxt.ea = idx_w + {`OAG_ZERO_BYTE, p0_r};
          M_IIDX_L: res_nxt.ea = word(p0_r, p1_r) + idx_w;
          // RULE12 displacement from following instruction
          M_REL: res_nxt.target = rel_target(pc_r, b0_r);
          M_REL_IND: res_nxt.target = rel_target(pc_r, p0_r);
          // RULE13 bit test and branch stays in page zero
          M_BITREL:
          begin
            res_nxt.ea = word(`OAG_ZERO_BYTE, b0_r);
            res_nxt.target = rel_target(pc_r, b1_r);
          end
          M_BITREL_IND:
          begin
            res_nxt.ea = word(`OAG_ZERO_BYTE, p0_r);
            res_nxt.target = rel_target(pc_r, b1_r);
          end
          default: res_nxt.ea = `OAG_ZERO_WORD;
        endcase
        done_nxt = 1'b1;
        busy_nxt = 1'b0;
        st_nxt = S_IDLE;
      end
      default:
      begin
        req_nxt = 1'b0;
        busy_nxt = 1'b0;
        st_nxt = S_IDLE;
      end
    endcase
  end

  // The index registers are sampled in the result cycle so a late update still counts.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= S_IDLE;
      mode_r <= M_INH;
      pc_r <= `OAG_ZERO_WORD;
      pre_r <= `OAG_ZERO_BYTE;
      op_r <= `OAG_ZERO_BYTE;
      b0_r <= `OAG_ZERO_BYTE;
      b1_r <= `OAG_ZERO_BYTE;
      p0_r <= `OAG_ZERO_BYTE;
      p1_r <= `OAG_ZERO_BYTE;
      cnt_r <= 2'h0;
      busy_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_addr_r <= `OAG_ZERO_WORD;
      done_r <= 1'b0;
      res_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      pc_r <= pc_nxt;
      pre_r <= pre_nxt;
      op_r <= op_nxt;
      b0_r <= b0_nxt;
      b1_r <= b1_nxt;
      p0_r <= p0_nxt;
      p1_r <= p1_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      mem_req_r <= req_nxt;
      mem_addr_r <= addr_nxt;
      done_r <= done_nxt;
      res_r <= res_nxt;
    end
  end

endmodule

// File: sim/operand_address_generator_chk.sv
/*
  Port checker for the operand address generator.
  Assumes a bind from the bench top file and one clock domain.
*/
`timescale 1ns/10ps
module operand_address_generator_chk
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Instruction request
  input wire logic start,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] x_idx,
  input wire logic [7:0] y_idx,
  input wire logic busy_r,
  // Memory read port
  input wire logic mem_req_r,
  input wire logic [15:0] mem_addr_r,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  // Result
  input wire logic done_r,
  input wire oag_pkg::result_t res_r
);
  import oag_pkg::*;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // The start address is kept so that lengths can be judged at done.
  always_comb pc_nxt = (start && !busy_r) ? pc_in : pc_r;
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      pc_r <= 16'h0000;
    else
      pc_r <= pc_nxt;
  function automatic logic [15:0] op_len(input mode_t m);
    case (m)
      M_INH, M_IDX_0: return 16'h0000;
      M_DIR_L, M_IDX_L, M_BITREL, M_BITREL_IND: return 16'h0002;
      default: return 16'h0001;
    endcase
  endfunction
  done_idle_a: assert property (done_r |-> !busy_r && $past(busy_r)) else $error("done while busy");
  done_pulse_a: assert property (done_r |=> !done_r) else $error("done longer than one cycle");
  req_hold_a: assert property (mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r))
    else $error("request dropped before ack");
  req_busy_a: assert property (mem_req_r |-> busy_r) else $error("request while idle");
  pc_len_a: assert property (done_r |-> res_r.next_pc == pc_r + 16'h0001 + op_len(res_r.mode)
    + {15'h0000, res_r.prebyte != 8'h00}) else $error("wrong instruction length");
  imm_ea_a: assert property (done_r && res_r.mode == M_IMM |-> res_r.ea == 16'h0000)
    else $error("immediate given an address");
  page_zero_a: assert property (done_r && res_r.mode inside {M_DIR_S, M_IND_S, M_BIT}
    |-> res_r.ea[15:8] == 8'h00) else $error("short form left page zero");
  idx_short_a: assert property (done_r && res_r.mode == M_IDX_S |-> res_r.ea <= 16'h01FE)
    else $error("short indexed out of range");
  idx_zero_a: assert property (done_r && res_r.mode == M_IDX_0
    |-> res_r.ea == {8'h00, res_r.use_y ? $past(y_idx) : $past(x_idx)}) else $error("bad no-offset address");
  rel_span_a: assert property (done_r && res_r.mode == M_REL
    |-> res_r.target - res_r.next_pc + 16'h0080 < 16'h0100) else $error("branch out of range");
  tgt_plain_a: assert property (done_r && !(res_r.mode inside {M_REL, M_REL_IND, M_BITREL, M_BITREL_IND})
    |-> res_r.target == res_r.next_pc) else $error("target not next pc");
  cover property (done_r && res_r.mode == M_IND_L);
  cover property (done_r && res_r.use_y);
  cover property ((mem_req_r && !mem_ack) [*2]);
  cover property (done_r && res_r.mode == M_BITREL_IND);
  cover property (start && done_r);
endmodule

// File: sim/mem_model.sv
/*
  Byte memory answering the generator's read port with a one-cycle ack.
  Assumes the bench fills the array before an instruction is run.
*/
`timescale 1ns/10ps
module mem_model
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Wait control
  input wire logic slow,
  // Read port
  input wire logic mem_req_r,
  input wire logic [15:0] mem_addr_r,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] mem [0:65535];
  logic [1:0] cnt_r;
  // Data is inverted each cycle between acks so a sample one cycle late never sees the stale byte.
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      cnt_r <= 2'h0;
    end
    else if (mem_req_r && !mem_ack && cnt_r >= (slow ? 2'h2 : 2'h0))
    begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr_r];
      cnt_r <= 2'h0;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt_r <= (mem_req_r && !mem_ack) ? cnt_r + 2'h1 : 2'h0;
    end
endmodule

// File: sim/tb_operand_address_generator.sv
/*
  Bench for the operand address generator: one task per addressing scenario.
  Assumes the memory model and the bound port checker.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t mismatch", $time); end end
module tb_operand_address_generator;
  import oag_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic [15:0] pc_in = 16'h0000;
  logic [7:0] x_idx = 8'hFF;
  logic [7:0] y_idx = 8'h21;
  logic busy_r, mem_req_r, mem_ack, done_r;
  logic [15:0] mem_addr_r;
  logic [7:0] mem_rdata;
  result_t res_r;
  int n_fail = 0;
  int n_compared = 0;
  always #20 sys_clk = ~sys_clk;
  operand_address_generator u_dut (.sys_clk(sys_clk), .resetn(resetn), .start(start), .pc_in(pc_in),
    .x_idx(x_idx), .y_idx(y_idx), .busy_r(busy_r), .mem_req_r(mem_req_r), .mem_addr_r(mem_addr_r),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .done_r(done_r), .res_r(res_r));
  mem_model u_mem (.sys_clk(sys_clk), .resetn(resetn), .slow(slow), .mem_req_r(mem_req_r),
    .mem_addr_r(mem_addr_r), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  task wrap_up;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task put(input logic [15:0] a, input logic [7:0] b[$]);
    foreach (b[i])
      u_mem.mem[a + i[15:0]] = b[i];
  endtask
  task wait_done;
    int i;
    i = 0;
    while (done_r !== 1'b1 && i < 60)
    begin
      @(negedge sys_clk);
      i++;
    end
    `CHK(done_r, 1'b1)
  endtask
  task run(input logic [15:0] p, input logic [7:0] b[$]);
    put(p, b);
    @(negedge sys_clk);
    pc_in = p;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    wait_done;
  endtask
  task chk(input mode_t m, input logic [15:0] ea, input logic [15:0] np, input logic y);
    `CHK(res_r.mode, m)
    `CHK(res_r.ea, ea)
    `CHK(res_r.next_pc, np)
    `CHK(res_r.use_y, y)
  endtask
  task t_inh_imm;
    run(16'h0100, '{8'h9D});
    chk(M_INH, 16'h0000, 16'h0101, 1'b0);
    run(16'h0200, '{8'hA6, 8'h55});
    chk(M_IMM, 16'h0000, 16'h0202, 1'b0);
    `CHK(res_r.operand, 8'h55)
    $display("t_inh_imm done");
  endtask
  task t_direct;
    run(16'h0300, '{8'hB6, 8'h10});
    chk(M_DIR_S, 16'h0010, 16'h0302, 1'b0);
    run(16'h0310, '{8'hC6, 8'h12, 8'h34});
    chk(M_DIR_L, 16'h1234, 16'h0313, 1'b0);
    run(16'h0320, '{8'h3A, 8'h10});
    chk(M_DIR_S, 16'h0010, 16'h0322, 1'b0);
    $display("t_direct done");
  endtask
  task t_indexed;
    run(16'h0400, '{8'hF6});
    chk(M_IDX_0, 16'h00FF, 16'h0401, 1'b0);
    run(16'h0410, '{8'hE6, 8'hFF});
    chk(M_IDX_S, 16'h01FE, 16'h0412, 1'b0);
    run(16'h0420, '{8'hD6, 8'hFF, 8'hF0});
    chk(M_IDX_L, 16'h00EF, 16'h0423, 1'b0);
    run(16'h0430, '{8'h90, 8'hF6});
    chk(M_IDX_0, 16'h0021, 16'h0432, 1'b1);
    $display("t_indexed done");
  endtask
  task t_indirect;
    // Slow answers stretch every byte, including the pointer reads.
    slow = 1'b1;
    put(16'h0040, '{8'hAB, 8'hCD});
    run(16'h0500, '{8'h92, 8'hB6, 8'h40});
    chk(M_IND_S, 16'h00AB, 16'h0503, 1'b0);
    run(16'h0510, '{8'h92, 8'hC6, 8'h40});
    chk(M_IND_L, 16'hABCD, 16'h0513, 1'b0);
    slow = 1'b0;
    run(16'h0600, '{8'h92, 8'hE6, 8'h40});
    chk(M_IIDX_S, 16'h01AA, 16'h0603, 1'b0);
    run(16'h0610, '{8'h91, 8'hE6, 8'h40});
    chk(M_IIDX_S, 16'h00CC, 16'h0613, 1'b1);
    $display("t_indirect done");
  endtask
  task t_relative;
    run(16'h0700, '{8'h20, 8'h80});
    chk(M_REL, 16'h0000, 16'h0702, 1'b0);
    `CHK(res_r.target, 16'h0682)
    run(16'h0710, '{8'h20, 8'h7F});
    `CHK(res_r.target, 16'h0791)
    $display("t_relative done");
  endtask
  task t_bitmodes;
    run(16'h0800, '{8'h10, 8'h10});
    chk(M_BIT, 16'h0010, 16'h0802, 1'b0);
    run(16'h0810, '{8'h92, 8'h10, 8'h40});
    chk(M_BIT_IND, 16'h00AB, 16'h0813, 1'b0);
    run(16'h0820, '{8'h00, 8'h10, 8'h05});
    chk(M_BITREL, 16'h0010, 16'h0823, 1'b0);
    `CHK(res_r.target, 16'h0828)
    run(16'h0830, '{8'h92, 8'h00, 8'h40, 8'hFE});
    chk(M_BITREL_IND, 16'h00AB, 16'h0834, 1'b0);
    `CHK(res_r.target, 16'h0832)
    run(16'h0840, '{8'h92, 8'h20, 8'h40});
    chk(M_REL_IND, 16'h0000, 16'h0843, 1'b0);
    `CHK(res_r.target, 16'h07EE)
    run(16'h0850, '{8'h92, 8'hD6, 8'h40});
    chk(M_IIDX_L, 16'hACCC, 16'h0853, 1'b0);
    `CHK(res_r.prebyte, 8'h92)
    `CHK(res_r.opcode, 8'hD6)
    `CHK(res_r.target, 16'h0853)
    run(16'h0860, '{8'h91, 8'hD6, 8'h40});
    chk(M_IIDX_L, 16'hABEE, 16'h0863, 1'b1);
    run(16'h0870, '{8'h6A, 8'h10});
    chk(M_IDX_S, 16'h010F, 16'h0872, 1'b0);
    run(16'h0880, '{8'h7A});
    chk(M_IDX_0, 16'h00FF, 16'h0881, 1'b0);
    run(16'h0890, '{8'h90, 8'hA6, 8'h33});
    chk(M_IMM, 16'h0000, 16'h0893, 1'b1);
    `CHK(res_r.operand, 8'h33)
    $display("t_bitmodes done");
  endtask
  task t_order;
    put(16'h0900, '{8'h9D});
    put(16'h0910, '{8'hA6, 8'h77});
    @(negedge sys_clk);
    pc_in = 16'h0900;
    start = 1'b1;
    @(negedge sys_clk);
    // Start stays high while busy, so a new address here must be ignored.
    pc_in = 16'h0A00;
    wait_done;
    `CHK(res_r.next_pc, 16'h0901)
    pc_in = 16'h0910;
    @(negedge sys_clk);
    start = 1'b0;
    wait_done;
    `CHK(res_r.mode, M_IMM)
    `CHK(res_r.operand, 8'h77)
    `CHK(res_r.next_pc, 16'h0912)
    $display("t_order done");
  endtask
  initial
  begin
    repeat (4) @(negedge sys_clk);
    resetn = 1'b1;
    t_inh_imm;
    t_direct;
    t_indexed;
    t_indirect;
    t_relative;
    t_bitmodes;
    t_order;
    wrap_up;
  end
  initial
  begin
    #200000;
    n_fail++;
    wrap_up;
  end
endmodule
bind operand_address_generator operand_address_generator_chk u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .start(start), .pc_in(pc_in), .x_idx(x_idx), .y_idx(y_idx), .busy_r(busy_r), .mem_req_r(mem_req_r),
  .mem_addr_r(mem_addr_r), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .done_r(done_r), .res_r(res_r));
